// ---- src/awv_params.svh ----
// Constants for the audio widget verb handler.
// How it works
// R1 - Input converter connection entries: 17h and 1Eh.
// R2 - 705h sets power state, F05h reads.
// R3 - Power response: actual 7:4, requested 3:0.
// R4 - 706h sets stream/channel, F06h reads back.
// R5 - Format get Ah, set 2h, resets 0031h.
// R6 - Format bit 15 fixed at PCM zero.
// R7 - Format bit 14 selects base rate.
// R8 - Multiplier codes x1, x2, x4 only.
// R9 - Divisor supports only divide by one.
// R10 - Sample width 16, 20, 24 bits only.
// R11 - Channel count stored minus one.
// R12 - Amp get: bit 13 side, bit 15 output.
// R13 - Converter amp resets muted, gain 0Bh.
// R14 - Amp set bit 14, sides 13/12, mute/gain.
// R15 - Mixer capability reads 0020050Bh.
// R16 - Mixer input amp capability 80051F17h.
// R17 - Mixer list seven entries, packed four.
// R18 - Mixer amp indexed, resets muted 17h; a set ignores the index and writes all seven inputs.
// R19 - First selector list six entries, packed.
// R20 - 701h/F01h selector index, resets to 1.
// R21 - First selector capability reads 00300501h.
// R22 - Later selectors capability reads 0030050Dh.
// R23 - Unknown node or bad format: zero, no change.
`ifndef AWV_PARAMS_SVH
`define AWV_PARAMS_SVH
`define AWV_NID_ADC0 8'h13
`define AWV_NID_ADC1 8'h14
`define AWV_NID_MIX 8'h16
`define AWV_NID_SEL0 8'h17
`define AWV_NID_SEL1 8'h18
`define AWV_NID_SEL2 8'h26
`define AWV_NID_SEL3 8'h27
`define AWV_V_GET_PARAM 12'hF00
`define AWV_V_GET_SEL 12'hF01
`define AWV_V_SET_SEL 12'h701
`define AWV_V_GET_LIST 12'hF02
`define AWV_V_GET_PWR 12'hF05
`define AWV_V_SET_PWR 12'h705
`define AWV_V_GET_STRM 12'hF06
`define AWV_V_SET_STRM 12'h706
`define AWV_V4_GET_FMT 4'hA
`define AWV_V4_SET_FMT 4'h2
`define AWV_V4_GET_AMP 4'hB
`define AWV_V4_SET_AMP 4'h3
`define AWV_P_WCAP 8'h09
`define AWV_P_INAMP 8'h0D
`define AWV_P_LISTLEN 8'h0E
`define AWV_P_PWRSUP 8'h0F
`define AWV_ADC_WCAP 32'h0010_051B
`define AWV_ADC_INAMP 32'h8005_1F0B
`define AWV_MIX_WCAP 32'h0020_050B
`define AWV_MIX_INAMP 32'h8005_1F17
`define AWV_SEL0_WCAP 32'h0030_0501
`define AWV_SELN_WCAP 32'h0030_050D
`define AWV_PWRSUP 32'h0000_000F
`define AWV_ADC_LEN 32'h0000_0001
`define AWV_MIX_LEN 32'h0000_0007
`define AWV_SEL0_LEN 32'h0000_0006
`define AWV_ADC0_SRC 32'h0000_0017
`define AWV_ADC1_SRC 32'h0000_001E
`define AWV_MIX_LIST0 32'h1B1A_1F10
`define AWV_MIX_LIST4 32'h0025_1D1E
`define AWV_SEL0_LIST0 32'h1E1B_1A1F
`define AWV_SEL0_LIST4 32'h0000_161D
`define AWV_FMT_RST 16'h0031
`define AWV_ADC_AMP_RST 8'h8B
`define AWV_MIX_AMP_RST 8'h97
`define AWV_SEL0_RST 8'h01
`define AWV_MIX_INPUTS 7
`endif

// ---- src/awv_pkg.sv ----
// Types for the audio widget verb handler.
`default_nettype none
package awv_pkg;
    typedef enum logic [1:0] {
        AWV_IDLE = 2'b00,
        AWV_RESP = 2'b01
    } awv_state_t;
endpackage : awv_pkg
`default_nettype wire

// ---- src/awv_verb_handler.sv ----
// Verb decoder and widget state for input converters, mixer and selectors.
`timescale 1ns/1ps
`default_nettype none
`include "awv_params.svh"
module awv_verb_handler
    import awv_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_link_resetn,
    input wire logic i_verb_valid,
    input wire logic [7:0] i_node_identifier,
    input wire logic [19:0] i_verb,
    output logic o_resp_valid,
    output logic [31:0] o_resp
);
    // Verb word: a 12-bit verb with 8-bit payload, or a 4-bit verb with 16-bit payload.
    // The verb strobe comes from link logic on this clock; link reset is a pin and is synchronised.
    logic lr_meta;
    logic lr_sync;
    awv_state_t state;
    awv_state_t next_state;
    logic [31:0] resp;
    logic [31:0] next_resp;
    logic [3:0] pwr_set [0:6];
    logic [3:0] next_pwr_set [0:6];
    logic [7:0] strm [0:1];
    logic [7:0] next_strm [0:1];
    logic [15:0] fmt [0:1];
    logic [15:0] next_fmt [0:1];
    logic [7:0] adc_amp [0:3];
    logic [7:0] next_adc_amp [0:3];
    logic [7:0] mix_amp [0:13];
    logic [7:0] next_mix_amp [0:13];
    logic [7:0] sel0;
    logic [7:0] next_sel0;
    // Decoded view of the verb word, shared by every state group.
    logic [2:0] slot;
    logic [11:0] verb12;
    logic [3:0] verb4;
    logic [7:0] pay8;
    logic [15:0] pay16;
    logic is_cvt;
    logic hit;
    logic [3:0] mix_idx;

    // Widget slot: 0,1 converters, 2 mixer, 3 first selector, 4..6 later selectors, 7 none.
    function automatic logic [2:0] slot_of(input logic [7:0] node_identifier);
        case (node_identifier)
            `AWV_NID_ADC0: slot_of = 3'd0;
            `AWV_NID_ADC1: slot_of = 3'd1;
            `AWV_NID_MIX: slot_of = 3'd2;
            `AWV_NID_SEL0: slot_of = 3'd3;
            `AWV_NID_SEL1: slot_of = 3'd4;
            `AWV_NID_SEL2: slot_of = 3'd5;
            `AWV_NID_SEL3: slot_of = 3'd6;
            default: slot_of = 3'd7;
        endcase
    endfunction : slot_of

    // Rejects unsupported type, multiplier, divisor and width codes.
    function automatic logic fmt_ok(input logic [15:0] f);
        fmt_ok = !f[15] // [R6]
            && (f[13:11] == 3'b000 || f[13:11] == 3'b001 || f[13:11] == 3'b011) // [R8]
            && (f[10:8] == 3'b000) // [R9]
            && (f[6:4] == 3'b001 || f[6:4] == 3'b010 || f[6:4] == 3'b011); // [R10]
    endfunction : fmt_ok

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            lr_meta <= 1'b0;
            lr_sync <= 1'b0;
        end else begin
            lr_meta <= i_link_resetn;
            lr_sync <= lr_meta;
        end
    end

    // Decode of the verb word; every state group reads these.
    assign slot = slot_of(i_node_identifier);
    assign verb12 = i_verb[19:8];
    assign verb4 = i_verb[19:16];
    assign pay8 = i_verb[7:0];
    assign pay16 = i_verb[15:0];
    assign is_cvt = (slot == 3'h0) || (slot == 3'h1);
    assign hit = i_verb_valid && (slot != 3'h7); // [R23]
    assign mix_idx = pay16[3:0];

    // Response group. Set verbs answer zero; gets read the stored state.
    always_comb begin
        next_state = AWV_IDLE;
        next_resp = resp;
        if (i_verb_valid) begin
            next_state = AWV_RESP;
            next_resp = 32'h0000_0000; // [R23]
            if (hit) begin
                if (verb12 == `AWV_V_GET_PARAM) begin
                    case (pay8)
                        `AWV_P_WCAP: begin
                            if (is_cvt) next_resp = `AWV_ADC_WCAP;
                            else if (slot == 3'h2) next_resp = `AWV_MIX_WCAP; // [R15]
                            else if (slot == 3'h3) next_resp = `AWV_SEL0_WCAP; // [R21]
                            else next_resp = `AWV_SELN_WCAP; // [R22]
                        end
                        `AWV_P_INAMP: begin
                            if (is_cvt) next_resp = `AWV_ADC_INAMP;
                            else if (slot == 3'h2) next_resp = `AWV_MIX_INAMP; // [R16]
                            else next_resp = 32'h0000_0000;
                        end
                        `AWV_P_LISTLEN: begin
                            if (slot == 3'h2) next_resp = `AWV_MIX_LEN; // [R17]
                            else if (slot == 3'h3) next_resp = `AWV_SEL0_LEN; // [R19]
                            else next_resp = `AWV_ADC_LEN;
                        end
                        `AWV_P_PWRSUP: next_resp = `AWV_PWRSUP;
                        default: next_resp = 32'h0000_0000;
                    endcase
                end else if (verb12 == `AWV_V_GET_LIST) begin
                    if (slot == 3'h0) next_resp = `AWV_ADC0_SRC; // [R1]
                    else if (slot == 3'h1) next_resp = `AWV_ADC1_SRC; // [R1]
                    else if (slot == 3'h2) begin
                        if (pay8 < 8'h04) next_resp = `AWV_MIX_LIST0; // [R17]
                        else if (pay8 < 8'h07) next_resp = `AWV_MIX_LIST4; // [R17]
                    end else if (slot == 3'h3) begin
                        if (pay8 < 8'h04) next_resp = `AWV_SEL0_LIST0; // [R19]
                        else if (pay8 < 8'h06) next_resp = `AWV_SEL0_LIST4; // [R19]
                    end
                end else if (verb12 == `AWV_V_GET_PWR) begin
                    // The widget settles at once, so the actual level equals the request.
                    next_resp = {24'h00_0000, pwr_set[slot], pwr_set[slot]}; // [R3]
                end else if (is_cvt && verb12 == `AWV_V_GET_STRM) begin
                    next_resp = {24'h00_0000, strm[slot[0]]}; // [R4]
                end else if (slot == 3'h3 && verb12 == `AWV_V_GET_SEL) begin
                    next_resp = {24'h00_0000, sel0}; // [R20]
                end else if (is_cvt && verb4 == `AWV_V4_GET_FMT) begin
                    next_resp = {16'h0000, fmt[slot[0]]}; // [R5]
                end else if (verb4 == `AWV_V4_GET_AMP) begin
                    // Output amplifier requests have no storage and read zero.
                    if (!pay16[15]) begin // [R12]
                        if (is_cvt) begin
                            next_resp = {24'h00_0000, adc_amp[{slot[0], pay16[13]}]}; // [R12] [R13]
                        end else if (slot == 3'h2 && mix_idx < 4'h7) begin
                            next_resp = {24'h00_0000, mix_amp[{mix_idx[2:0], pay16[13]}]}; // [R18]
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= AWV_IDLE;
            resp <= 32'h0000_0000;
        end else begin
            state <= next_state;
            resp <= next_resp;
        end
    end

    // Power group. Link reset wins over a set in the same cycle, so no stale level survives.
    always_comb begin
        next_pwr_set = pwr_set;
        if (hit && verb12 == `AWV_V_SET_PWR && pay8 <= 8'h03) begin
            next_pwr_set[slot] = pay8[3:0]; // [R2]
        end
        if (!lr_sync) begin
            for (int k = 0; k < 7; k++) begin
                next_pwr_set[k] = 4'h0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int k = 0; k < 7; k++) begin
                pwr_set[k] <= 4'h0;
            end
        end else begin
            pwr_set <= next_pwr_set;
        end
    end

    // Stream group: one stream and channel byte per input converter.
    always_comb begin
        next_strm = strm;
        if (hit && is_cvt && verb12 == `AWV_V_SET_STRM) begin
            next_strm[slot[0]] = pay8; // [R4]
        end
        if (!lr_sync) begin
            for (int k = 0; k < 2; k++) begin
                next_strm[k] = 8'h00;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int k = 0; k < 2; k++) begin
                strm[k] <= 8'h00;
            end
        end else begin
            strm <= next_strm;
        end
    end

    // Format group. A set with any unsupported code is dropped whole, never half applied.
    always_comb begin
        next_fmt = fmt;
        if (hit && is_cvt && verb4 == `AWV_V4_SET_FMT && fmt_ok(pay16)) begin // [R23]
            // Bits 14 and 3:0 store directly; bits 15 and 7 stay zero.
            next_fmt[slot[0]] = {1'b0, pay16[14:8], 1'b0, pay16[6:0]}; // [R6] [R7] [R11]
        end
        if (!lr_sync) begin
            for (int k = 0; k < 2; k++) begin
                next_fmt[k] = `AWV_FMT_RST; // [R5]
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int k = 0; k < 2; k++) begin
                fmt[k] <= `AWV_FMT_RST;
            end
        end else begin
            fmt <= next_fmt;
        end
    end

    // Converter amplifier group: words indexed {converter, left}.
    always_comb begin
        next_adc_amp = adc_amp;
        if (hit && is_cvt && verb4 == `AWV_V4_SET_AMP && pay16[14]) begin // [R14]
            if (pay16[13]) next_adc_amp[{slot[0], 1'b1}] = pay16[7:0]; // [R14]
            if (pay16[12]) next_adc_amp[{slot[0], 1'b0}] = pay16[7:0]; // [R14]
        end
        if (!lr_sync) begin
            for (int k = 0; k < 4; k++) begin
                next_adc_amp[k] = `AWV_ADC_AMP_RST; // [R13]
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int k = 0; k < 4; k++) begin
                adc_amp[k] <= `AWV_ADC_AMP_RST;
            end
        end else begin
            adc_amp <= next_adc_amp;
        end
    end

    // Mixer amplifier group: words indexed {input, left}.
    always_comb begin
        next_mix_amp = mix_amp;
        if (hit && slot == 3'h2 && verb4 == `AWV_V4_SET_AMP && pay16[14]) begin // [R14]
            // The index field of a set is ignored, so all mixer inputs follow.
            for (int k = 0; k < `AWV_MIX_INPUTS; k++) begin
                if (pay16[13]) next_mix_amp[2 * k + 1] = pay16[7:0];
                if (pay16[12]) next_mix_amp[2 * k] = pay16[7:0];
            end
        end
        if (!lr_sync) begin
            for (int k = 0; k < 14; k++) begin
                next_mix_amp[k] = `AWV_MIX_AMP_RST; // [R18]
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int k = 0; k < 14; k++) begin
                mix_amp[k] <= `AWV_MIX_AMP_RST;
            end
        end else begin
            mix_amp <= next_mix_amp;
        end
    end

    // Selector group: an index past the six list entries is refused.
    always_comb begin
        next_sel0 = sel0;
        if (hit && slot == 3'h3 && verb12 == `AWV_V_SET_SEL && pay8 < 8'h06) begin
            next_sel0 = pay8; // [R20]
        end
        if (!lr_sync) begin
            next_sel0 = `AWV_SEL0_RST; // [R20]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sel0 <= `AWV_SEL0_RST;
        end else begin
            sel0 <= next_sel0;
        end
    end

    assign o_resp_valid = (state == AWV_RESP);
    assign o_resp = resp;
endmodule : awv_verb_handler
`default_nettype wire

// ---- testbench/awv_ctrl_model.sv ----
// Controller-side model that issues one verb and collects its answer.
`timescale 1ns/1ps
`default_nettype none
module awv_ctrl_model (
    input wire logic i_clk_sys,
    input wire logic i_resp_valid,
    input wire logic [31:0] i_resp,
    output var logic o_verb_valid,
    output var logic [7:0] o_node,
    output var logic [19:0] o_verb
);
    initial begin
        o_verb_valid = 1'b0;
        o_node = 8'h00;
        o_verb = 20'h0_0000;
    end
    task automatic xfer(input logic [7:0] nd, input logic [19:0] vb, output logic [31:0] rsp,
        output bit ok);
        @(posedge i_clk_sys);
        o_verb_valid <= 1'b1;
        o_node <= nd;
        o_verb <= vb;
        @(posedge i_clk_sys);
        o_verb_valid <= 1'b0;
        // Released lines flip so a stale value can never pass for a held one.
        o_node <= ~nd;
        o_verb <= ~vb;
        #1;
        ok = (i_resp_valid === 1'b1);
        rsp = i_resp;
    endtask : xfer
endmodule : awv_ctrl_model
`default_nettype wire

// ---- testbench/awv_verb_handler_assertions.sv ----
// Port checker for the audio widget verb handler.
`timescale 1ns/1ps
`default_nettype none
module awv_verb_chk (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_link_resetn,
    input wire logic i_verb_valid,
    input wire logic [7:0] i_node_identifier,
    input wire logic [19:0] i_verb,
    input wire logic o_resp_valid,
    input wire logic [31:0] o_resp
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    logic [7:0] n;
    logic t;
    assign n = i_node_identifier;
    assign t = i_verb_valid;
    property p_ans;
        1'b1 |=> o_resp_valid == $past(i_verb_valid);
    endproperty
    a_ans: assert property (p_ans) else $error("answer pulse wrong");
    property p_pwr;
        t && n == 8'h13 && i_verb[19:8] == 12'hF05 |=> o_resp[31:8] == 24'h0 && o_resp[7:4] == o_resp[3:0];
    endproperty
    a_pwr: assert property (p_pwr) else $error("power word wrong");
    property p_list;
        t && n inside {8'h13, 8'h14} && i_verb[19:8] == 12'hF02
            |=> o_resp == ($past(n) == 8'h13 ? 32'h17 : 32'h1E);
    endproperty
    a_list: assert property (p_list) else $error("converter source wrong");
    property p_fmt;
        t && n == 8'h13 && i_verb[19:16] == 4'hA |=> o_resp[31:15] == 17'h0;
    endproperty
    a_fmt: assert property (p_fmt) else $error("format top bits set");
    property p_mcap;
        t && n == 8'h16 && i_verb == 20'hF_0009 |=> o_resp == 32'h0020_050B;
    endproperty
    a_mcap: assert property (p_mcap) else $error("mixer caps wrong");
    property p_mamp;
        t && n == 8'h16 && i_verb == 20'hF_000D |=> o_resp == 32'h8005_1F17;
    endproperty
    a_mamp: assert property (p_mamp) else $error("mixer amp caps wrong");
    property p_mlist;
        t && n == 8'h16 && i_verb == 20'hF_0200 |=> o_resp == 32'h1B1A_1F10;
    endproperty
    a_mlist: assert property (p_mlist) else $error("mixer list wrong");
    property p_scap;
        t && n == 8'h17 && i_verb == 20'hF_0009 |=> o_resp == 32'h0030_0501;
    endproperty
    a_scap: assert property (p_scap) else $error("selector caps wrong");
    property p_ncap;
        t && n inside {8'h18, 8'h26, 8'h27} && i_verb == 20'hF_0009 |=> o_resp == 32'h0030_050D;
    endproperty
    a_ncap: assert property (p_ncap) else $error("later selector caps wrong");
    property p_unk;
        t && !(n inside {8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h26, 8'h27}) |=> o_resp == 32'h0;
    endproperty
    a_unk: assert property (p_unk) else $error("unknown node answered");
    c_mix: cover property (t && n == 8'h16);
    c_sel: cover property (t && n == 8'h17);
    c_lrst: cover property (!i_link_resetn);
endmodule : awv_verb_chk
bind awv_verb_handler awv_verb_chk u_chk (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_link_resetn(i_link_resetn), .i_verb_valid(i_verb_valid),
    .i_node_identifier(i_node_identifier), .i_verb(i_verb), .o_resp_valid(o_resp_valid),
    .o_resp(o_resp));
`default_nettype wire

// ---- testbench/awv_verb_handler_tb_top.sv ----
// Self-checking bench for the audio widget verb handler.
`timescale 1ns/1ps
`default_nettype none
module awv_verb_handler_tb_top;
    typedef struct {logic [7:0] n; logic [19:0] v; logic [31:0] e;} awv_row_t;
    logic clk;
    logic rst_n;
    logic lrst_n;
    logic vld;
    logic [7:0] nd;
    logic [19:0] vb;
    logic rv;
    logic [31:0] rs;
    logic [31:0] got;
    bit ok;
    int bad_count;
    int n_checks;
    awv_row_t rows[] = '{'{8'h13, 20'hF_0200, 32'h17}, '{8'h14, 20'hF_0200, 32'h1E},
        '{8'h13, 20'hA_0000, 32'h31}, '{8'h13, 20'hB_2000, 32'h8B}, '{8'h13, 20'h7_0502, 32'h0},
        '{8'h13, 20'hF_0500, 32'h22}, '{8'h13, 20'h7_0504, 32'h0}, '{8'h13, 20'hF_0500, 32'h22},
        '{8'h13, 20'h7_0635, 32'h0}, '{8'h13, 20'hF_0600, 32'h35}, '{8'h13, 20'h2_4831, 32'h0},
        '{8'h13, 20'h2_5031, 32'h0}, '{8'h13, 20'h2_6031, 32'h0}, '{8'h13, 20'h2_4931, 32'h0},
        '{8'h13, 20'h2_4801, 32'h0}, '{8'h13, 20'hA_0000, 32'h4831}, '{8'h13, 20'h3_6005, 32'h0},
        '{8'h13, 20'h3_B07F, 32'h0}, '{8'h13, 20'hB_2000, 32'h5}, '{8'h13, 20'hB_0000, 32'h8B},
        '{8'h13, 20'hB_A000, 32'h0}, '{8'h16, 20'hF_0009, 32'h0020_050B},
        '{8'h16, 20'hF_000D, 32'h8005_1F17}, '{8'h16, 20'hF_0204, 32'h0025_1D1E},
        '{8'h16, 20'hF_0200, 32'h1B1A_1F10}, '{8'h16, 20'hB_2003, 32'h97},
        '{8'h16, 20'hB_0007, 32'h0}, '{8'h17, 20'hF_0009, 32'h0030_0501},
        '{8'h17, 20'hF_0200, 32'h1E1B_1A1F}, '{8'h17, 20'hF_0204, 32'h161D},
        '{8'h17, 20'hF_0100, 32'h1}, '{8'h17, 20'h7_0105, 32'h0}, '{8'h17, 20'h7_0106, 32'h0},
        '{8'h17, 20'hF_0100, 32'h5}, '{8'h18, 20'hF_0009, 32'h0030_050D},
        '{8'h26, 20'hF_0009, 32'h0030_050D}, '{8'h27, 20'hF_0009, 32'h0030_050D},
        '{8'h30, 20'hF_0009, 32'h0}, '{8'h13, 20'h2_C831, 32'h0},
        '{8'h13, 20'hA_0000, 32'h4831}, '{8'h14, 20'hA_0000, 32'h31},
        '{8'h14, 20'h7_06A3, 32'h0}, '{8'h14, 20'hF_0600, 32'hA3}, '{8'h13, 20'hF_0600, 32'h35},
        '{8'h16, 20'hF_000E, 32'h7}, '{8'h17, 20'hF_000E, 32'h6}, '{8'h18, 20'hF_000E, 32'h1},
        '{8'h16, 20'hF_0207, 32'h0}, '{8'h17, 20'hF_0206, 32'h0}, '{8'h16, 20'h3_7085, 32'h0},
        '{8'h16, 20'hB_2006, 32'h85}, '{8'h16, 20'hB_0000, 32'h85}, '{8'h16, 20'h7_0503, 32'h0},
        '{8'h16, 20'hF_0500, 32'h33}, '{8'h14, 20'h3_5011, 32'h0}, '{8'h14, 20'hB_0000, 32'h11},
        '{8'h14, 20'hB_2000, 32'h8B}};
    awv_verb_handler dut (.i_clk_sys(clk), .i_resetn(rst_n), .i_link_resetn(lrst_n),
        .i_verb_valid(vld), .i_node_identifier(nd), .i_verb(vb), .o_resp_valid(rv), .o_resp(rs));
    awv_ctrl_model ctl (.i_clk_sys(clk), .i_resp_valid(rv), .i_resp(rs), .o_verb_valid(vld),
        .o_node(nd), .o_verb(vb));
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    task automatic run(input logic [7:0] n, input logic [19:0] v, input logic [31:0] e);
        ctl.xfer(n, v, got, ok);
        n_checks++;
        if (!ok) begin
            bad_count++;
            $display("Error at %0t: no answer, got %h expected %h", $time, 1'b0, 1'b1);
            finish_test();
        end else if (got !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, e);
        end
    endtask : run
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        lrst_n = 1'b1;
        bad_count = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[k]) begin
            run(rows[k].n, rows[k].v, rows[k].e);
        end
        $display("Table test done");
        // Link reset must restore defaults without the main reset.
        @(posedge clk);
        lrst_n <= 1'b0;
        repeat (4) @(posedge clk);
        lrst_n <= 1'b1;
        repeat (3) @(posedge clk);
        run(8'h13, 20'hA_0000, 32'h31);
        run(8'h17, 20'hF_0100, 32'h1);
        run(8'h13, 20'hB_2000, 32'h8B);
        $display("Link reset test done");
        // A main reset in mid-run must also restore defaults; first verb right after release.
        run(8'h17, 20'h7_0103, 32'h0);
        run(8'h17, 20'h7_0503, 32'h0);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        run(8'h17, 20'hF_0100, 32'h1);
        run(8'h17, 20'hF_0500, 32'h0);
        run(8'h13, 20'hA_0000, 32'h31);
        $display("Main reset test done");
        finish_test();
    end
endmodule : awv_verb_handler_tb_top
`default_nettype wire
